// *** src/gain_switch_regs.vh ***
`ifndef GAIN_SWITCH_REGS_VH
`define GAIN_SWITCH_REGS_VH

// Register byte offsets.
`define OFS_SWITCH_CFG      8'h00
`define OFS_SWITCH_THRESH   8'h04
`define OFS_SWITCH_TC       8'h08
`define OFS_ALT_INERTIA     8'h0C
`define OFS_ALT_POS_GAIN    8'h10
`define OFS_ALT_SPD_GAIN    8'h14
`define OFS_ALT_INTEG       8'h18
`define OFS_ALT_VIB_FREQ    8'h1C
`define OFS_ALT_RES_FREQ    8'h20
`define OFS_TUNE_MODES      8'h24
`define OFS_SWITCH_STATUS   8'h28

// Field positions.
`define SRC_LSB             0
`define SRC_MSB             2
`define DIR_BIT             4
`define GAIN_MODE_LSB       0
`define GAIN_MODE_MSB       1
`define VIB_MODE_LSB        4
`define VIB_MODE_MSB        5
`define ST_COND_BIT         0
`define ST_TARGET_BIT       1
`define ST_FRAC_LSB         4
`define ST_FRAC_MSB         12

// Source and mode encodings.
`define SRC_DISABLED        3'h0
`define SRC_HOST_CMD        3'h1
`define SRC_CMD_FREQ        3'h2
`define SRC_DROOP           3'h3
`define SRC_SPEED           3'h4
`define GAIN_MODE_MANUAL    2'h3
`define VIB_MODE_MANUAL     2'h2

// Reset values.
`define RST_SOURCE          3'h0
`define RST_DIR             1'h0
`define RST_THRESH          16'h000A
`define RST_TC_MS           7'h01
`define RST_ALT_INERTIA     16'h02BC
`define RST_ALT_ZERO        16'h0000
`define RST_GAIN_MODE       2'h1
`define RST_VIB_MODE        2'h0

// Fallback limits and the time-constant ceiling in stored units.
`define MIN_ALT_POS_GAIN    16'h000A
`define MIN_ALT_SPD_GAIN    16'h0014
`define MIN_ALT_INTEG       16'h0001
`define MIN_ALT_FREQ        16'h0001
`define MAX_TC_MS           7'h64

// Timing.
`define CLK_HZ              100000000
`define TIME_BASE_MS        1
`define MS_CYCLES           (`CLK_HZ / 1000 * `TIME_BASE_MS)
`define CTRL_CYCLES_DEF     50
`define FRAC_SHIFT          8
`define FRAC_FULL           9'h100

`endif

// *** src/gain_blend.v ***
`timescale 1ns/1ps
// Blends one gain between its base value and its alternate value.
module gain_blend #(
	parameter         W       = 16,
	parameter [W-1:0] MIN_ALT = {W{1'b0}}
) (
	input  wire         aclk,
	input  wire         aresetn,
	input  wire [W-1:0] base,
	input  wire [W-1:0] alt,
	input  wire         enable,
	input  wire [8:0]   frac,
	output reg  [W-1:0] gain
);
	wire [W-1:0]        alt_eff;
	wire signed [W:0]   diff;
	wire signed [W+10:0] prod;
	wire [W-1:0]        next_gain;

	assign alt_eff   = (enable && alt >= MIN_ALT) ? alt : base;
	assign diff      = $signed({1'b0, alt_eff}) - $signed({1'b0, base});
	assign prod      = diff * $signed({1'b0, frac});
	assign next_gain = base + prod[W+7:8];

	always @(posedge aclk) begin
		if (!aresetn)
			gain <= {W{1'b0}};
		else
			gain <= next_gain;
	end
endmodule

// *** src/servo_gain_set_switcher.v ***
// Functional notes
// - Source 0 off, 1 host command, 2 frequency, 3 droop, 4 speed; default 0.
// - Direction 0 switches at or above threshold, 1 at or below; default 0.
// - Threshold 0 to 65535, default 10, unit follows selected source.
// - Gains move to the new set over a 0 to 100 ms time constant.
// - When the condition holds, alternate values replace the base values.
// - Alternate inertia ratio 0.00 to 300.00, default 7.00; the register takes any 16-bit value with no limit at 300.00.
// - Alternate inertia and loop gains act only in manual gain mode 3.
// - Alternate position gain below 1.0 rad/s falls back to base.
// - Alternate speed gain below 20 rad/s falls back to base.
// - Alternate integral compensation below 0.1 ms falls back to base.
// - Alternate vibration frequency below 0.1 Hz falls back to base.
// - Alternate vibration frequency needs gain mode 3, tuning 2, source 1.
// - Alternate resonance frequency behaves like the vibration frequency.
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "gain_switch_regs.vh"

module servo_gain_set_switcher #(
	parameter MS_CYCLES   = `MS_CYCLES,
	parameter CTRL_CYCLES = `CTRL_CYCLES_DEF
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        host_switch_cmd,
	input  wire [31:0] cmd_frequency,
	input  wire [31:0] droop_pulses,
	input  wire [31:0] motor_speed,
	input  wire [15:0] base_inertia_ratio,
	input  wire [15:0] base_position_gain,
	input  wire [15:0] base_speed_gain,
	input  wire [15:0] base_integral_comp,
	input  wire [15:0] base_vib_frequency,
	input  wire [15:0] base_resonance_frequency,
	output wire [15:0] active_inertia_ratio,
	output wire [15:0] active_position_gain,
	output wire [15:0] active_speed_gain,
	output wire [15:0] active_integral_comp,
	output wire [15:0] active_vib_frequency,
	output wire [15:0] active_resonance_frequency,
	output reg         alt_gains_active
);
	localparam [1:0] RESP_OKAY   = 2'h0;
	localparam [1:0] RESP_SLVERR = 2'h2;

	// Software-visible settings.
	reg  [2:0]  switch_source_select;
	reg         switch_direction;
	reg  [15:0] switch_threshold;
	reg  [6:0]  switch_time_constant;
	reg  [15:0] alt_inertia_ratio;
	reg  [15:0] alt_position_gain;
	reg  [15:0] alt_speed_gain;
	reg  [15:0] alt_integral_comp;
	reg  [15:0] alt_vib_frequency;
	reg  [15:0] alt_resonance_frequency;
	reg  [1:0]  gain_adjust_mode_setting;
	reg  [1:0]  vib_tuning_mode_setting;

	// Write channel state.
	reg         aw_held;
	reg  [7:0]  aw_addr;
	reg         w_held;
	reg  [31:0] w_data;
	reg  [3:0]  w_strb;
	wire        aw_take;
	wire        w_take;
	wire        wr_fire;
	wire [7:0]  wr_addr;
	wire [31:0] wr_data;
	wire [3:0]  wr_strb;

	// Switching state.
	reg  [31:0] ctrl_count;
	wire        ctrl_tick;
	reg         cond_met;
	reg  [31:0] monitored;
	reg         next_cond;
	reg  [8:0]  frac;
	reg  [31:0] step_count;
	wire [31:0] step_period;
	wire        step_due;
	wire        manual_gain;
	wire        vib_alt_enable;

	reg  [31:0] read_word;
	reg         read_ok;

	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0]  strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1)
				if (strb[i])
					merge[i*8 +: 8] = data[i*8 +: 8];
		end
	endfunction

	// Address and data are accepted in either order and held until both
	// are present, so the response never races ahead of either half.
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign aw_take       = s_axi_awvalid && s_axi_awready;
	assign w_take        = s_axi_wvalid && s_axi_wready;
	assign wr_addr       = aw_held ? aw_addr : s_axi_awaddr;
	assign wr_data       = w_held ? w_data : s_axi_wdata;
	assign wr_strb       = w_held ? w_strb : s_axi_wstrb;
	assign wr_fire       = (aw_held || aw_take) && (w_held || w_take);

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
			w_held  <= 1'b0;
			w_data  <= 32'h00000000;
			w_strb  <= 4'h0;
		end else if (wr_fire) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
		end else begin
			if (aw_take) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (w_take) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			if (wr_addr[7:2] <= `OFS_TUNE_MODES >> 2 && wr_addr[1:0] == 2'h0)
				s_axi_bresp <= RESP_OKAY;
			else
				s_axi_bresp <= RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Register writes.
	always @(posedge aclk) begin : reg_write
		reg [31:0] m;
		m = 32'h00000000;
		if (!aresetn) begin
			switch_source_select     <= `RST_SOURCE;
			switch_direction         <= `RST_DIR;
			switch_threshold         <= `RST_THRESH;
			switch_time_constant     <= `RST_TC_MS;
			alt_inertia_ratio        <= `RST_ALT_INERTIA;
			alt_position_gain        <= `RST_ALT_ZERO;
			alt_speed_gain           <= `RST_ALT_ZERO;
			alt_integral_comp        <= `RST_ALT_ZERO;
			alt_vib_frequency        <= `RST_ALT_ZERO;
			alt_resonance_frequency  <= `RST_ALT_ZERO;
			gain_adjust_mode_setting <= `RST_GAIN_MODE;
			vib_tuning_mode_setting  <= `RST_VIB_MODE;
		end else if (wr_fire) begin
			case (wr_addr)
			`OFS_SWITCH_CFG: begin
				m = merge({27'h0, switch_direction, 1'b0,
					switch_source_select}, wr_data, wr_strb);
				switch_source_select <= m[`SRC_MSB:`SRC_LSB];
				switch_direction     <= m[`DIR_BIT];
			end
			`OFS_SWITCH_THRESH: begin
				m = merge({16'h0, switch_threshold}, wr_data, wr_strb);
				switch_threshold <= m[15:0];
			end
			`OFS_SWITCH_TC: begin
				m = merge({25'h0, switch_time_constant}, wr_data, wr_strb);
				// Values past the top of the range are held at 100 ms.
				if (m[31:7] != 25'h0 || m[6:0] > `MAX_TC_MS)
					switch_time_constant <= `MAX_TC_MS;
				else
					switch_time_constant <= m[6:0];
			end
			`OFS_ALT_INERTIA: begin
				m = merge({16'h0, alt_inertia_ratio}, wr_data, wr_strb);
				alt_inertia_ratio <= m[15:0];
			end
			`OFS_ALT_POS_GAIN: begin
				m = merge({16'h0, alt_position_gain}, wr_data, wr_strb);
				alt_position_gain <= m[15:0];
			end
			`OFS_ALT_SPD_GAIN: begin
				m = merge({16'h0, alt_speed_gain}, wr_data, wr_strb);
				alt_speed_gain <= m[15:0];
			end
			`OFS_ALT_INTEG: begin
				m = merge({16'h0, alt_integral_comp}, wr_data, wr_strb);
				alt_integral_comp <= m[15:0];
			end
			`OFS_ALT_VIB_FREQ: begin
				m = merge({16'h0, alt_vib_frequency}, wr_data, wr_strb);
				alt_vib_frequency <= m[15:0];
			end
			`OFS_ALT_RES_FREQ: begin
				m = merge({16'h0, alt_resonance_frequency}, wr_data,
					wr_strb);
				alt_resonance_frequency <= m[15:0];
			end
			`OFS_TUNE_MODES: begin
				m = merge({26'h0, vib_tuning_mode_setting, 2'h0,
					gain_adjust_mode_setting}, wr_data, wr_strb);
				gain_adjust_mode_setting <=
					m[`GAIN_MODE_MSB:`GAIN_MODE_LSB];
				vib_tuning_mode_setting <= m[`VIB_MODE_MSB:`VIB_MODE_LSB];
			end
			default: begin
			end
			endcase
		end
	end

	// Read path.
	assign s_axi_arready = !s_axi_rvalid;

	always @* begin
		read_ok   = 1'b1;
		read_word = 32'h00000000;
		case (s_axi_araddr)
		`OFS_SWITCH_CFG:
			read_word = {27'h0, switch_direction, 1'b0,
				switch_source_select};
		`OFS_SWITCH_THRESH: read_word = {16'h0, switch_threshold};
		`OFS_SWITCH_TC:     read_word = {25'h0, switch_time_constant};
		`OFS_ALT_INERTIA:   read_word = {16'h0, alt_inertia_ratio};
		`OFS_ALT_POS_GAIN:  read_word = {16'h0, alt_position_gain};
		`OFS_ALT_SPD_GAIN:  read_word = {16'h0, alt_speed_gain};
		`OFS_ALT_INTEG:     read_word = {16'h0, alt_integral_comp};
		`OFS_ALT_VIB_FREQ:  read_word = {16'h0, alt_vib_frequency};
		`OFS_ALT_RES_FREQ:  read_word = {16'h0, alt_resonance_frequency};
		`OFS_TUNE_MODES:
			read_word = {26'h0, vib_tuning_mode_setting, 2'h0,
				gain_adjust_mode_setting};
		`OFS_SWITCH_STATUS:
			read_word = {19'h0, frac, 2'h0, alt_gains_active, cond_met};
		default: read_ok = 1'b0;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= read_word;
			s_axi_rresp  <= read_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Control-cycle timer.
	assign ctrl_tick = (ctrl_count == CTRL_CYCLES - 1);

	always @(posedge aclk) begin
		if (!aresetn || ctrl_tick)
			ctrl_count <= 32'h00000000;
		else
			ctrl_count <= ctrl_count + 32'h00000001;
	end

	// Switching condition.
	always @* begin
		case (switch_source_select)
		`SRC_CMD_FREQ: monitored = cmd_frequency;
		`SRC_DROOP:    monitored = droop_pulses;
		`SRC_SPEED:    monitored = motor_speed;
		default:       monitored = 32'h00000000;
		endcase
		case (switch_source_select)
		`SRC_HOST_CMD: next_cond = host_switch_cmd;
		`SRC_CMD_FREQ, `SRC_DROOP, `SRC_SPEED:
			if (switch_direction)
				next_cond = monitored <= {16'h0, switch_threshold};
			else
				next_cond = monitored >= {16'h0, switch_threshold};
		default: next_cond = 1'b0;
		endcase
	end

	// The condition is latched only on the control tick so that a noisy
	// monitored value cannot chatter the gains between cycles.
	always @(posedge aclk) begin
		if (!aresetn) begin
			cond_met         <= 1'b0;
			alt_gains_active <= 1'b0;
		end else if (ctrl_tick) begin
			cond_met         <= next_cond;
			alt_gains_active <= next_cond;
		end
	end

	// Ramp of the blend fraction between the two sets.
	assign step_period = (switch_time_constant * MS_CYCLES)
		>> `FRAC_SHIFT;
	assign step_due    = (switch_time_constant == 7'h00) ||
		(step_count + 32'h00000001 >= step_period);

	always @(posedge aclk) begin
		if (!aresetn) begin
			step_count <= 32'h00000000;
			frac       <= 9'h000;
		end else if (step_due) begin
			step_count <= 32'h00000000;
			if (switch_time_constant == 7'h00)
				frac <= alt_gains_active ? `FRAC_FULL : 9'h000;
			else if (alt_gains_active && frac != `FRAC_FULL)
				frac <= frac + 9'h001;
			else if (!alt_gains_active && frac != 9'h000)
				frac <= frac - 9'h001;
		end else begin
			step_count <= step_count + 32'h00000001;
		end
	end

	assign manual_gain    = gain_adjust_mode_setting == `GAIN_MODE_MANUAL;
	assign vib_alt_enable = manual_gain &&
		vib_tuning_mode_setting == `VIB_MODE_MANUAL &&
		switch_source_select == `SRC_HOST_CMD;

	gain_blend #(.W(16), .MIN_ALT(16'h0000)) blend_inertia (
		.aclk(aclk), .aresetn(aresetn), .base(base_inertia_ratio),
		.alt(alt_inertia_ratio), .enable(manual_gain), .frac(frac),
		.gain(active_inertia_ratio));
	gain_blend #(.W(16), .MIN_ALT(`MIN_ALT_POS_GAIN)) blend_pos (
		.aclk(aclk), .aresetn(aresetn), .base(base_position_gain),
		.alt(alt_position_gain), .enable(manual_gain), .frac(frac),
		.gain(active_position_gain));
	gain_blend #(.W(16), .MIN_ALT(`MIN_ALT_SPD_GAIN)) blend_speed (
		.aclk(aclk), .aresetn(aresetn), .base(base_speed_gain),
		.alt(alt_speed_gain), .enable(manual_gain), .frac(frac),
		.gain(active_speed_gain));
	gain_blend #(.W(16), .MIN_ALT(`MIN_ALT_INTEG)) blend_integ (
		.aclk(aclk), .aresetn(aresetn), .base(base_integral_comp),
		.alt(alt_integral_comp), .enable(manual_gain), .frac(frac),
		.gain(active_integral_comp));
	// Vibration values also follow the ramp; the host is expected to switch
	// them only at standstill since a change in motion jolts the load.
	gain_blend #(.W(16), .MIN_ALT(`MIN_ALT_FREQ)) blend_vib (
		.aclk(aclk), .aresetn(aresetn), .base(base_vib_frequency),
		.alt(alt_vib_frequency), .enable(vib_alt_enable), .frac(frac),
		.gain(active_vib_frequency));
	gain_blend #(.W(16), .MIN_ALT(`MIN_ALT_FREQ)) blend_res (
		.aclk(aclk), .aresetn(aresetn), .base(base_resonance_frequency),
		.alt(alt_resonance_frequency), .enable(vib_alt_enable),
		.frac(frac), .gain(active_resonance_frequency));
endmodule

// *** bench/host_ctrl_model.sv ***
`timescale 1ns/1ps
module host_ctrl_model (
	input  wire         aclk,
	output logic        host_switch_cmd,
	output logic [31:0] cmd_frequency,
	output logic [31:0] droop_pulses,
	output logic [31:0] motor_speed
);
	initial begin
		host_switch_cmd = 1'h0;
		cmd_frequency = 32'h00000000;
		droop_pulses = 32'h00000000;
		motor_speed = 32'h00000000;
	end
	// The drive is stopped before every host-commanded swap, since a swap
	// in motion jolts the load.
	task automatic command(input logic on);
		@(posedge aclk);
		motor_speed <= 32'h00000000;
		@(posedge aclk);
		host_switch_cmd <= on;
	endtask
	task automatic monitor(input logic [31:0] f, d, s);
		@(posedge aclk);
		cmd_frequency <= f;
		droop_pulses <= d;
		motor_speed <= s;
	endtask
endmodule

// *** bench/servo_gain_set_switcher_sva.sv ***
`timescale 1ns/1ps
module servo_gain_set_switcher_sva #(
	parameter CTRL_CYCLES = 50
) (
	input wire        aclk,
	input wire        aresetn,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [31:0] s_axi_rdata,
	input wire        alt_gains_active
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic        prev_alt;
	logic [15:0] since;
	// Reset counts as long ago, so the first switch is never flagged.
	always_ff @(posedge aclk) begin
		prev_alt <= alt_gains_active;
		if (!aresetn)
			since <= 16'hFFFF;
		else if (prev_alt != alt_gains_active)
			since <= 16'h0001;
		else if (since != 16'hFFFF)
			since <= since + 16'h0001;
	end
	a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid drop");
	a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid drop");
	a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("awready during response");
	a_w_blocked: assert property (s_axi_bvalid |-> !s_axi_wready)
		else $error("wready during response");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("arready during read data");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("read data late");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
		else $error("write response late");
	a_reset_idle: assert property (
		$rose(aresetn) |-> !alt_gains_active && !s_axi_bvalid
		&& !s_axi_rvalid) else $error("outputs busy after reset");
	a_cond_spacing: assert property (
		prev_alt != alt_gains_active |-> since >= CTRL_CYCLES)
		else $error("switch between control cycles");
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_alt_on: cover property ($rose(alt_gains_active));
	c_alt_off: cover property ($fell(alt_gains_active));
endmodule

bind servo_gain_set_switcher servo_gain_set_switcher_sva #(
	.CTRL_CYCLES(CTRL_CYCLES)
) chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.s_axi_rdata, .alt_gains_active);

// *** bench/servo_gain_set_switcher_tb_top.sv ***
`timescale 1ns/1ps
module servo_gain_set_switcher_tb_top;
	logic aclk = 1'h0, aresetn = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, alt_gains_active, host_switch_cmd;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, cmd_frequency, droop_pulses, motor_speed;
	logic [15:0] base_inertia_ratio, base_position_gain, base_speed_gain;
	logic [15:0] base_integral_comp, base_vib_frequency;
	logic [15:0] base_resonance_frequency, active_inertia_ratio;
	logic [15:0] active_position_gain, active_speed_gain;
	logic [15:0] active_integral_comp, active_vib_frequency;
	logic [15:0] active_resonance_frequency;
	logic [15:0] base_v [6] = '{16'h0190, 16'h0120, 16'h0200, 16'h0050,
		16'h0070, 16'h00A0};
	logic [15:0] alt_v [6] = '{16'h02BC, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000};
	logic [31:0] rst_v [10] = '{32'h0, 32'hA, 32'h1, 32'h2BC, 32'h0,
		32'h0, 32'h0, 32'h0, 32'h0, 32'h1};
	logic [31:0] o;
	logic e;
	int error_cnt = 0, cmp_count = 0, cyc = 0;
	assign base_inertia_ratio = base_v[0];
	assign base_position_gain = base_v[1];
	assign base_speed_gain = base_v[2];
	assign base_integral_comp = base_v[3];
	assign base_vib_frequency = base_v[4];
	assign base_resonance_frequency = base_v[5];

	// Short counts keep the ramp test to a few hundred cycles.
	servo_gain_set_switcher #(.MS_CYCLES(256), .CTRL_CYCLES(4)) dut (.*);
	host_ctrl_model host (.*);

	always #5 aclk = ~aclk;

	task automatic results;
		$display("checks %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			results();
		end
	end

	task automatic chk(input logic [31:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		forever begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid)
				break;
		end
		s_axi_bready <= 1'h0;
		chk({30'h0, s_axi_bresp}, {30'h0, r});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		forever begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid)
				break;
		end
		s_axi_rready <= 1'h0;
		chk(s_axi_rdata, d);
		chk({30'h0, s_axi_rresp}, {30'h0, r});
	endtask

	task automatic set_alt(input logic [15:0] v [6]);
		for (int i = 0; i < 6; i++) begin
			alt_v[i] = v[i];
			wr(8'h0C + {3'h0, i[2:0], 2'h0}, {16'h0000, v[i]}, 2'h0);
		end
	endtask

	// Covers one control cycle, the jump and the output register.
	task automatic settle;
		repeat (12) @(posedge aclk);
	endtask

	task automatic gains(input logic [5:0] m);
		logic [15:0] g [6];
		g = '{active_inertia_ratio, active_position_gain, active_speed_gain,
			active_integral_comp, active_vib_frequency,
			active_resonance_frequency};
		for (int i = 0; i < 6; i++)
			chk({16'h0000, g[i]}, {16'h0000, m[i] ? alt_v[i] : base_v[i]});
	endtask

	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		for (int i = 0; i < 10; i++)
			rd({i[5:0], 2'h0}, rst_v[i], 2'h0);
		rd(8'h2C, 32'h0, 2'h2);
		wr(8'h28, 32'h1, 2'h2);
		// Only byte lane 1 is written; lane 0 keeps the reset threshold.
		s_axi_wstrb <= 4'h2;
		wr(8'h04, 32'h00001234, 2'h0);
		s_axi_wstrb <= 4'hF;
		rd(8'h04, 32'h0000120A, 2'h0);
		gains(6'h00);
		wr(8'h08, 32'h0, 2'h0);
		wr(8'h24, 32'h23, 2'h0);
		set_alt('{16'h0258, 16'h0032, 16'h0064, 16'h001E, 16'h0028,
			16'h003C});
		wr(8'h00, 32'h1, 2'h0);
		host.command(1'h1);
		settle();
		chk({31'h0, alt_gains_active}, 32'h1);
		gains(6'h3F);
		host.command(1'h0);
		settle();
		gains(6'h00);
		host.command(1'h1);
		set_alt('{16'h0258, 16'h0009, 16'h0013, 16'h0000, 16'h0000,
			16'h0000});
		settle();
		gains(6'h01);
		set_alt('{16'h0258, 16'h000A, 16'h0014, 16'h0001, 16'h0001,
			16'h0001});
		settle();
		gains(6'h3F);
		wr(8'h24, 32'h03, 2'h0);
		settle();
		gains(6'h0F);
		wr(8'h24, 32'h21, 2'h0);
		settle();
		gains(6'h00);
		// New base values must reach the outputs while the base set rules.
		base_v <= '{16'h0300, 16'h0100, 16'h0180, 16'h0040, 16'h0060,
			16'h0090};
		settle();
		gains(6'h00);
		wr(8'h24, 32'h23, 2'h0);
		wr(8'h00, 32'h0, 2'h0);
		settle();
		chk({31'h0, alt_gains_active}, 32'h0);
		gains(6'h00);
		host.command(1'h0);
		wr(8'h04, 32'h1F4, 2'h0);
		for (int s = 2; s < 5; s++)
			for (int d = 0; d < 2; d++)
				for (int v = 499; v < 502; v++) begin
					wr(8'h00, {27'h0, d[0], 1'h0, s[2:0]}, 2'h0);
					o = d ? 32'hFFFFFFFF : 32'h00000000;
					host.monitor(s == 2 ? v : o, s == 3 ? v : o,
						s == 4 ? v : o);
					settle();
					e = d ? (v <= 500) : (v >= 500);
					chk({31'h0, alt_gains_active}, {31'h0, e});
					if (e)
						chk({16'h0, active_vib_frequency}, {16'h0, base_v[4]});
				end
		host.monitor(32'h0, 32'h0, 32'h0);
		wr(8'h00, 32'h1, 2'h0);
		wr(8'h08, 32'hC8, 2'h0);
		rd(8'h08, 32'h64, 2'h0);
		wr(8'h08, 32'h1, 2'h0);
		host.command(1'h1);
		repeat (100) @(posedge aclk);
		o = {16'h0, active_position_gain};
		chk({31'h0, o[15:0] !== alt_v[1] && o[15:0] !== base_v[1]}, 32'h1);
		repeat (300) @(posedge aclk);
		gains(6'h3F);
		rd(8'h28, 32'h00001003, 2'h0);
		host.command(1'h0);
		aresetn <= 1'h0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		rd(8'h00, 32'h0, 2'h0);
		gains(6'h00);
		results();
	end
endmodule
